// *** hw/edc_pkg.sv ***
// Function
// R1 - Eight identical channels, each with its own control and status registers.
// R2 - Each channel copies RAM to peripheral or peripheral to RAM.
// R3 - Transfers use a dedicated bus, never the processor's.
// R4 - A channel raises an interrupt when a block completes.
// R5 - Optionally the interrupt fires at half block instead.
// R6 - Simultaneous requests are arbitrated by fixed priority.
// R7 - Ping-pong swaps between two RAM start addresses after each block.
// R8 - Transfers start by software force or by the selected peripheral request.
// R9 - Addressing: indirect with post-increment, without, or peripheral indirect.
// R10 - Each channel moves single bytes or full words.
// R11 - One-shot stops after a block; auto-repeat restarts continuously.
// R12 - Code 00h selects external interrupt 0, no peripheral address.
// R13 - Capture 1 code 01h at 0140h; capture 2 code 05h at 0144h.
// R14 - Compare 1 code 02h writes 0182h primary or 0180h secondary.
// R15 - Compare 2 code 06h writes 0188h primary or 0186h secondary.
// R16 - Serial port 1 code 0Ah at 0248h; port 2 code 21h at 0268h.
// R17 - UART 1 receive 0Bh reads 0226h; transmit 0Ch writes 0224h.
// R18 - UART 2 receive 1Eh reads 0236h; transmit 1Fh writes 0234h.
// R19 - Converter done code 0Dh reads first result at 0300h.
// R20 - CAN receive 22h reads 0440h; CAN transmit 46h writes 0442h.
// R21 - Parallel port code 2Dh uses 0608h for reads and writes.
// R22 - Each channel selects its request from any source by a field.
// R23 - The lowest-numbered requesting channel wins the bus first.
package edc_pkg;
    localparam int CH_COUNT  = 8;
    localparam int IRQ_COUNT = 128;
    localparam int ADDR_W    = 8;
    localparam int CNT_W     = 10;
    localparam int SEL_W     = 7;
    // Register indices inside a channel, channel in bits 5:3
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_REQ  = 3'h1;
    localparam logic [2:0] REG_STA  = 3'h2;
    localparam logic [2:0] REG_STB  = 3'h3;
    localparam logic [2:0] REG_PAD  = 3'h4;
    localparam logic [2:0] REG_CNT  = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h40;
    // Control word fields
    localparam int B_EN = 15, B_SIZE = 14, B_DIR = 13, B_HALF = 12, B_NULLW = 11;
    localparam int AMOD_LSB = 4, MODE_ONESHOT = 0, MODE_PP = 1, B_FORCE = 15;
    localparam logic [15:0] CTRL_MASK = 16'hf833;
    localparam logic [1:0]  AM_INC = 2'h0, AM_FIX = 2'h1;
    localparam logic [15:0] STEP_BYTE = 16'h0001, STEP_WORD = 16'h0002;
    // Request source codes
    localparam logic [6:0] RQ_INT0 = 7'h00, RQ_IC1 = 7'h01, RQ_OC1 = 7'h02;
    localparam logic [6:0] RQ_IC2 = 7'h05, RQ_OC2 = 7'h06, RQ_SPI1 = 7'h0a;
    localparam logic [6:0] RQ_U1RX = 7'h0b, RQ_U1TX = 7'h0c, RQ_ADC = 7'h0d;
    localparam logic [6:0] RQ_U2RX = 7'h1e, RQ_U2TX = 7'h1f, RQ_SPI2 = 7'h21;
    localparam logic [6:0] RQ_CANRX = 7'h22, RQ_PMP = 7'h2d, RQ_CANTX = 7'h46;

    typedef enum {ST_IDLE, ST_READ, ST_CAPT, ST_WRITE} edc_state_t;

    // One side of the transfer bus
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
        logic        byte_mode;
    } edc_bus_t;

    // Default peripheral address for a source: {known, address}
    function automatic logic [16:0] periph_addr_lookup(input logic [6:0] code,
                                                       input logic to_per);
        logic [16:0] r;
        r = 17'h00000;
        case (code)
            RQ_INT0:  r = 17'h00000; // R12
            RQ_IC1:   r = to_per ? 17'h00000 : 17'h10140; // R13
            RQ_IC2:   r = to_per ? 17'h00000 : 17'h10144; // R13
            RQ_OC1:   r = to_per ? 17'h10182 : 17'h00000; // R14
            RQ_OC2:   r = to_per ? 17'h10188 : 17'h00000; // R15
            RQ_SPI1:  r = 17'h10248; // R16
            RQ_SPI2:  r = 17'h10268; // R16
            RQ_U1RX:  r = to_per ? 17'h00000 : 17'h10226; // R17
            RQ_U1TX:  r = to_per ? 17'h10224 : 17'h00000; // R17
            RQ_U2RX:  r = to_per ? 17'h00000 : 17'h10236; // R18
            RQ_U2TX:  r = to_per ? 17'h10234 : 17'h00000; // R18
            RQ_ADC:   r = to_per ? 17'h00000 : 17'h10300; // R19
            RQ_CANRX: r = to_per ? 17'h00000 : 17'h10440; // R20
            RQ_CANTX: r = to_per ? 17'h10442 : 17'h00000; // R20
            RQ_PMP:   r = 17'h10608; // R21
            default:  r = 17'h00000;
        endcase
        return r;
    endfunction
endpackage

// *** hw/edc_dma_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module edc_dma_top import edc_pkg::*; #(
    parameter int NUM_CH  = CH_COUNT,
    parameter int NUM_IRQ = IRQ_COUNT
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [15:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [15:0]         reg_rdata,
    // Peripheral request lines, asynchronous
    input  wire logic [NUM_IRQ-1:0]  periph_irq,
    // Offset given by peripheral in indirect mode
    input  wire logic [15:0]         periph_offset,
    // Dedicated transfer bus, RAM side
    output var  edc_bus_t            ram_bus,
    input  wire logic [15:0]         ram_rdata,
    // Dedicated transfer bus, peripheral side
    output var  edc_bus_t            per_bus,
    input  wire logic [15:0]         per_rdata,
    // Block interrupt pulses
    output logic      [NUM_CH-1:0]   ch_irq
);
    localparam int CH_W = $clog2(NUM_CH);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [15:0]       ctrl_reg [NUM_CH];
    logic [SEL_W-1:0]  sel_reg  [NUM_CH];
    logic [15:0]       sta_reg  [NUM_CH];
    logic [15:0]       stb_reg  [NUM_CH];
    logic [15:0]       pad_reg  [NUM_CH];
    logic [CNT_W-1:0]  cnt_reg  [NUM_CH];
    logic [15:0]       addr_reg [NUM_CH];
    logic [CNT_W-1:0]  done_reg [NUM_CH];
    logic [NUM_CH-1:0] force_reg;
    logic [NUM_CH-1:0] auto_reg;
    logic [NUM_CH-1:0] pp_reg;
    logic [NUM_CH-1:0] req;
    logic [NUM_CH-1:0] fin;
    logic [NUM_IRQ-1:0] irq_s1_reg, irq_s2_reg, irq_old_reg, irq_edge;
    edc_state_t        state_reg;
    logic [CH_W-1:0]   gnt_reg;
    logic [CH_W-1:0]   pick;
    logic [15:0]       data_reg;
    logic              last, half_hit;

    // Register decode, shared by write and read paths
    function automatic logic hit(input logic [ADDR_W-1:0] a, input int ch,
                                 input logic [2:0] r);
        return a == {2'b00, ch[2:0], r};
    endfunction

    // Lowest requesting channel wins
    function automatic logic [CH_W-1:0] lowest(input logic [NUM_CH-1:0] r);
        logic [CH_W-1:0] idx;
        idx = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (r[i]) begin
                idx = i[CH_W-1:0];
            end
        end
        return idx;
    endfunction

    // ************************************************************
    // Request synchronisers
    // ************************************************************
    // Two flops, then edge detect on the second stage only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_s1_reg  <= '0;
            irq_s2_reg  <= '0;
            irq_old_reg <= '0;
        end else begin
            irq_s1_reg  <= periph_irq;
            irq_s2_reg  <= irq_s1_reg;
            irq_old_reg <= irq_s2_reg;
        end
    end
    assign irq_edge = irq_s2_reg & ~irq_old_reg;

    // Granted channel status
    assign last     = done_reg[gnt_reg] == cnt_reg[gnt_reg];
    assign half_hit = done_reg[gnt_reg] == (cnt_reg[gnt_reg] >> 1);
    assign pick     = lowest(req); // R23

    // ************************************************************
    // Channel register sets
    // ************************************************************
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch // R1
        logic wr_ctrl, wr_req, en_rise, oneshot_end;
        logic pp_mode, pp_next;
        logic [16:0] pad_dflt;
        assign wr_ctrl = reg_wr && hit(reg_addr, c, REG_CTRL);
        assign wr_req  = reg_wr && hit(reg_addr, c, REG_REQ);
        // Default address for the code being written, with the current direction
        assign pad_dflt = periph_addr_lookup(reg_wdata[SEL_W-1:0], ctrl_reg[c][B_DIR]);
        assign en_rise = wr_ctrl && reg_wdata[B_EN] && !ctrl_reg[c][B_EN];
        assign fin[c]  = (state_reg == ST_WRITE) && (gnt_reg == c);
        assign pp_mode = ctrl_reg[c][MODE_PP];
        assign pp_next = pp_reg[c] ^ pp_mode;
        // One-shot ping-pong ends only after the second buffer
        assign oneshot_end = fin[c] && last && ctrl_reg[c][MODE_ONESHOT]
                             && (!pp_mode || pp_reg[c]);
        assign req[c] = ctrl_reg[c][B_EN] && (force_reg[c] || auto_reg[c]);

        // Control: software write beats the hardware stop
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                ctrl_reg[c] <= '0;
            end else if (wr_ctrl) begin
                ctrl_reg[c] <= reg_wdata & CTRL_MASK;
            end else if (oneshot_end) begin
                ctrl_reg[c][B_EN] <= 1'b0; // R11
            end
        end

        // Source select; also preloads the peripheral address
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                sel_reg[c] <= '0;
                pad_reg[c] <= '0;
            end else if (wr_req) begin
                sel_reg[c] <= reg_wdata[SEL_W-1:0]; // R22
                if (pad_dflt[16]) begin
                    pad_reg[c] <= pad_dflt[15:0];
                end
            end else if (reg_wr && hit(reg_addr, c, REG_PAD)) begin
                pad_reg[c] <= reg_wdata;
            end
        end

        // Start addresses and count
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                sta_reg[c] <= '0;
                stb_reg[c] <= '0;
                cnt_reg[c] <= '0;
            end else begin
                if (reg_wr && hit(reg_addr, c, REG_STA)) begin
                    sta_reg[c] <= reg_wdata;
                end
                if (reg_wr && hit(reg_addr, c, REG_STB)) begin
                    stb_reg[c] <= reg_wdata;
                end
                if (reg_wr && hit(reg_addr, c, REG_CNT)) begin
                    cnt_reg[c] <= reg_wdata[CNT_W-1:0];
                end
            end
        end

        // Force and peripheral requests: a new set wins over the clear
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                force_reg[c] <= 1'b0;
                auto_reg[c]  <= 1'b0;
            end else begin
                if (wr_req && reg_wdata[B_FORCE]) begin
                    force_reg[c] <= 1'b1; // R8
                end else if (fin[c]) begin
                    force_reg[c] <= 1'b0;
                end
                if (ctrl_reg[c][B_EN] && irq_edge[sel_reg[c]]) begin
                    auto_reg[c] <= 1'b1; // R8
                end else if (fin[c] && !force_reg[c]) begin
                    auto_reg[c] <= 1'b0;
                end
            end
        end

        // Buffer pointer, transfer tally and ping-pong side
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                addr_reg[c] <= '0;
                done_reg[c] <= '0;
                pp_reg[c]   <= 1'b0;
            end else if (en_rise) begin
                addr_reg[c] <= sta_reg[c];
                done_reg[c] <= '0;
                pp_reg[c]   <= 1'b0;
            end else if (fin[c] && last) begin
                addr_reg[c] <= pp_next ? stb_reg[c] : sta_reg[c]; // R7
                done_reg[c] <= '0; // R11
                pp_reg[c]   <= pp_next; // R7
            end else if (fin[c]) begin
                done_reg[c] <= done_reg[c] + 1'b1;
                if (ctrl_reg[c][AMOD_LSB +: 2] == AM_INC) begin // R9
                    addr_reg[c] <= addr_reg[c] + (ctrl_reg[c][B_SIZE] ? STEP_BYTE : STEP_WORD);
                end
            end
        end

        // Block or half-block interrupt
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                ch_irq[c] <= 1'b0;
            end else begin
                ch_irq[c] <= fin[c] && (ctrl_reg[c][B_HALF] ? half_hit : last); // R4 R5
            end
        end
    end

    // ************************************************************
    // Transfer engine on the dedicated bus
    // ************************************************************
    // Read source, wait one cycle for data, write destination
    always_ff @(posedge sys_clk) begin // R3
        if (rst) begin
            state_reg <= ST_IDLE;
            gnt_reg   <= '0;
            data_reg  <= '0;
            ram_bus   <= '0;
            per_bus   <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (|req) begin // R6
                        gnt_reg <= pick; // R23
                        ram_bus.addr <= ctrl_reg[pick][AMOD_LSB + 1]
                            ? (ctrl_reg[pick][MODE_PP] && pp_reg[pick] ? stb_reg[pick]
                                : sta_reg[pick]) + periph_offset
                            : addr_reg[pick]; // R9
                        per_bus.addr <= pad_reg[pick];
                        ram_bus.byte_mode <= ctrl_reg[pick][B_SIZE]; // R10
                        per_bus.byte_mode <= ctrl_reg[pick][B_SIZE]; // R10
                        ram_bus.rd <= ctrl_reg[pick][B_DIR]; // R2
                        per_bus.rd <= !ctrl_reg[pick][B_DIR]; // R2
                        state_reg <= ST_READ;
                    end
                end
                ST_READ: begin
                    ram_bus.rd <= 1'b0;
                    per_bus.rd <= 1'b0;
                    state_reg  <= ST_CAPT;
                end
                ST_CAPT: begin
                    // Data is valid the cycle after the read strobe
                    if (ctrl_reg[gnt_reg][B_DIR]) begin
                        per_bus.wdata <= ram_rdata;
                        per_bus.wr    <= 1'b1; // R2
                        data_reg      <= ram_rdata;
                    end else begin
                        ram_bus.wdata <= per_rdata;
                        ram_bus.wr    <= 1'b1; // R2
                        data_reg      <= per_rdata;
                        // Null write keeps a receive-only peripheral clocking
                        per_bus.wdata <= '0;
                        per_bus.wr    <= ctrl_reg[gnt_reg][B_NULLW];
                    end
                    state_reg <= ST_WRITE;
                end
                ST_WRITE: begin
                    ram_bus.wr <= 1'b0;
                    per_bus.wr <= 1'b0;
                    state_reg  <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    // Start-address reads return the live pointer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_rd && reg_addr == ADDR_STATUS) begin
                reg_rdata <= {req, pp_reg};
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (reg_rd && hit(reg_addr, c, REG_CTRL)) begin
                    reg_rdata <= ctrl_reg[c];
                end
                if (reg_rd && hit(reg_addr, c, REG_REQ)) begin
                    reg_rdata <= {force_reg[c], 8'h00, sel_reg[c]};
                end
                if (reg_rd && (hit(reg_addr, c, REG_STA) || hit(reg_addr, c, REG_STB))) begin
                    reg_rdata <= addr_reg[c];
                end
                if (reg_rd && hit(reg_addr, c, REG_PAD)) begin
                    reg_rdata <= pad_reg[c];
                end
                if (reg_rd && hit(reg_addr, c, REG_CNT)) begin
                    reg_rdata <= {6'h00, cnt_reg[c]};
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_src_read;
        ram_bus.rd || per_bus.rd;
    endsequence
    sequence s_dst_write;
        ram_bus.wr || per_bus.wr;
    endsequence

    chk_read_then_write: assert property ( // R2
        s_src_read |-> ##2 s_dst_write ##1 !(ram_bus.wr || per_bus.wr))
        else $error("write did not follow read by two cycles");
    chk_single_source: assert property ( // R3
        !(ram_bus.rd && per_bus.rd))
        else $error("both bus sides read at once");
    chk_fixed_grant: assert property ( // R23
        (state_reg == ST_IDLE && |req) |=> gnt_reg == $past(pick))
        else $error("grant not lowest requester");
    chk_force_served: assert property ( // R8
        $rose(force_reg[0]) && ctrl_reg[0][B_EN] |-> ##[1:40] fin[0])
        else $error("forced transfer not served");
    chk_irq_pulse: assert property ( // R4
        ch_irq[gnt_reg] |-> $past(state_reg) == ST_WRITE)
        else $error("interrupt without completed transfer");
    chk_post_inc: assert property ( // R9
        fin[0] && !last && ctrl_reg[0][AMOD_LSB +: 2] == AM_INC && !ctrl_reg[0][B_SIZE]
        |=> addr_reg[0] == $past(addr_reg[0]) + STEP_WORD)
        else $error("pointer not incremented");
    chk_fixed_addr: assert property ( // R9
        fin[5] && !last && ctrl_reg[5][AMOD_LSB +: 2] == AM_FIX && !reg_wr
        |=> $stable(addr_reg[5]))
        else $error("pointer moved in fixed mode");
    chk_byte_flag: assert property ( // R10
        s_src_read |-> ram_bus.byte_mode == ctrl_reg[gnt_reg][B_SIZE])
        else $error("byte flag mismatch");
    chk_oneshot_stop: assert property ( // R11
        fin[3] && last && ctrl_reg[3][MODE_ONESHOT] && !ctrl_reg[3][MODE_PP] && !reg_wr
        |=> !ctrl_reg[3][B_EN])
        else $error("one-shot channel still enabled");
    chk_pp_swap: assert property ( // R7
        fin[0] && last && ctrl_reg[0][MODE_PP] && !reg_wr |=> pp_reg[0] != $past(pp_reg[0]))
        else $error("ping-pong side did not swap");
endmodule
`default_nettype wire

// *** sim/edc_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module edc_far_model import edc_pkg::*; (
    // Clock
    input  wire logic        sys_clk,
    // Transfer bus from the controller
    input  wire edc_bus_t    ram_bus,
    input  wire edc_bus_t    per_bus,
    // Read answers, one cycle after the read
    output logic      [15:0] ram_rdata = 16'h5a5a,
    output logic      [15:0] per_rdata = 16'h3c3c
);
    // RAM word is its address inverted, peripheral word tags its address;
    // outside a read the lines toggle so stale data cannot pass for a match
    always_ff @(posedge sys_clk) begin
        ram_rdata <= ram_bus.rd ? ~ram_bus.addr : ~ram_rdata;
        per_rdata <= per_bus.rd ? {8'ha5, per_bus.addr[7:0]} : ~per_rdata;
    end
endmodule
`default_nettype wire

// *** sim/edc_dma_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module edc_dma_top_tb import edc_pkg::*;;
    typedef struct packed {
        logic [6:0]  code;
        logic        dir;
        logic [15:0] pad;
    } edc_row_t;
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   reg_addr = 8'h00;
    logic [15:0]  reg_wdata = 16'h0000;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [15:0]  reg_rdata;
    logic [127:0] periph_irq = '0;
    logic [15:0]  periph_offset = 16'h0000;
    edc_bus_t     ram_bus;
    edc_bus_t     per_bus;
    logic [15:0]  ram_rdata;
    logic [15:0]  per_rdata;
    logic [7:0]   ch_irq;
    int           n_fail = 0;
    int           comparisons = 0;
    int           irq_seen [8] = '{default: 0};
    edc_bus_t     b;
    logic [15:0]  d;
    // Source code, direction, default peripheral address
    edc_row_t rows [14] = '{
        '{RQ_IC1, 1'b0, 16'h0140}, '{RQ_IC2, 1'b0, 16'h0144},
        '{RQ_OC1, 1'b1, 16'h0182}, '{RQ_OC2, 1'b1, 16'h0188},
        '{RQ_SPI1, 1'b0, 16'h0248}, '{RQ_SPI2, 1'b1, 16'h0268},
        '{RQ_U1RX, 1'b0, 16'h0226}, '{RQ_U1TX, 1'b1, 16'h0224},
        '{RQ_U2RX, 1'b0, 16'h0236}, '{RQ_U2TX, 1'b1, 16'h0234},
        '{RQ_ADC, 1'b0, 16'h0300}, '{RQ_CANRX, 1'b0, 16'h0440},
        '{RQ_CANTX, 1'b1, 16'h0442}, '{RQ_PMP, 1'b1, 16'h0608}
    };
    edc_dma_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .periph_irq(periph_irq), .periph_offset(periph_offset), .ram_bus(ram_bus),
        .ram_rdata(ram_rdata), .per_bus(per_bus), .per_rdata(per_rdata), .ch_irq(ch_irq));
    edc_far_model far (.sys_clk(sys_clk), .ram_bus(ram_bus), .per_bus(per_bus),
        .ram_rdata(ram_rdata), .per_rdata(per_rdata));
    // **************************************************
    // Clock, interrupt tally, helpers
    // **************************************************
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (ch_irq[i] === 1'b1) begin
                irq_seen[i]++;
            end
        end
    end
    function automatic logic [7:0] ra(input int ch, input logic [2:0] r);
        return {2'h0, 3'(ch), r};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // Bounded wait for a write strobe on one side of the transfer bus
    task automatic wait_wr(input bit ram_side, output edc_bus_t t);
        t = '0;
        for (int k = 0; k < 30; k++) begin
            @(posedge sys_clk);
            #1;
            if ((ram_side ? ram_bus.wr : per_bus.wr) === 1'b1) begin
                t = ram_side ? ram_bus : per_bus;
                return;
            end
        end
        chk(16'h0000, 16'h0001);
    endtask
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        chk(16'h0000, 16'h0001);
        print_verdict();
    end
    // **************************************************
    // Tests
    // **************************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        bus_rd(ra(7, REG_CTRL), d);
        chk(d, 16'h0000);
        bus_rd(8'h07, d);
        chk(d, 16'h0000);
        foreach (rows[i]) begin
            bus_wr(ra(i, REG_CTRL), {2'h0, rows[i].dir, 13'h0000});
            bus_wr(ra(i, REG_REQ), {9'h000, rows[i].code});
            bus_rd(ra(i, REG_PAD), d);
            chk(d, rows[i].pad);
            bus_rd(ra(i, REG_REQ), d);
            chk(d, {9'h000, rows[i].code});
        end
        // Forced one-shot word block, RAM to peripheral, post-increment
        bus_wr(ra(3, REG_STA), 16'h0010);
        bus_wr(ra(3, REG_CNT), 16'h0001);
        bus_wr(ra(3, REG_CTRL), 16'ha001);
        bus_wr(ra(3, REG_REQ), {9'h100, RQ_U1TX});
        wait_wr(1'b0, b);
        chk(b.addr, 16'h0224);
        chk(b.wdata, 16'hffef);
        bus_wr(ra(3, REG_REQ), {9'h100, RQ_U1TX});
        wait_wr(1'b0, b);
        chk(b.wdata, 16'hffed);
        repeat (4) @(posedge sys_clk);
        chk(16'(irq_seen[3]), 16'h0001);
        bus_rd(ra(3, REG_CTRL), d);
        chk(d, 16'h2001);
        // Two peripheral requests at once, byte, fixed address
        bus_wr(ra(5, REG_STA), 16'h0080);
        bus_wr(ra(6, REG_STA), 16'h00a0);
        bus_wr(ra(5, REG_CNT), 16'h0001);
        bus_wr(ra(5, REG_CTRL), 16'hc010);
        bus_wr(ra(6, REG_CTRL), 16'hc010);
        bus_wr(ra(5, REG_REQ), {9'h000, RQ_U1RX});
        bus_wr(ra(6, REG_REQ), {9'h000, RQ_U2RX});
        @(posedge sys_clk);
        periph_irq[RQ_U1RX] <= 1'b1;
        periph_irq[RQ_U2RX] <= 1'b1;
        wait_wr(1'b1, b);
        chk(b.addr, 16'h0080);
        chk({8'h00, b.wdata[7:0]}, 16'h0026);
        chk({15'h0000, b.byte_mode}, 16'h0001);
        wait_wr(1'b1, b);
        chk(b.addr, 16'h00a0);
        @(posedge sys_clk);
        periph_irq <= '0;
        repeat (4) @(posedge sys_clk);
        periph_irq[RQ_U1RX] <= 1'b1;
        wait_wr(1'b1, b);
        chk(b.addr, 16'h0080);
        // Ping-pong with half-block interrupt
        bus_wr(ra(0, REG_STA), 16'h0100);
        bus_wr(ra(0, REG_STB), 16'h0200);
        bus_wr(ra(0, REG_CNT), 16'h0001);
        bus_wr(ra(0, REG_CTRL), 16'hb002);
        repeat (2) begin
            bus_wr(ra(0, REG_REQ), {9'h100, RQ_OC1});
            wait_wr(1'b0, b);
        end
        repeat (4) @(posedge sys_clk);
        chk(16'(irq_seen[0]), 16'h0001);
        bus_rd(ADDR_STATUS, d);
        chk({15'h0000, d[0]}, 16'h0001);
        bus_wr(ra(0, REG_REQ), {9'h100, RQ_OC1});
        wait_wr(1'b0, b);
        chk(b.wdata, 16'hfdff);
        // Peripheral indirect with null write, peripheral to RAM
        bus_wr(ra(1, REG_STA), 16'h0300);
        periph_offset <= 16'h0006;
        bus_wr(ra(1, REG_CTRL), 16'h8820);
        bus_wr(ra(1, REG_REQ), {9'h100, RQ_IC1});
        wait_wr(1'b1, b);
        chk(b.addr, 16'h0306);
        chk(b.wdata, 16'ha540);
        chk({15'h0000, per_bus.wr}, 16'h0001);
        print_verdict();
    end
endmodule
`default_nettype wire
